// File: logic/dsa_pkg.sv
// Function
// - I/O address low 16 bits, upper byte ones
// - I/O address never steps after transfers
// - Single address mode ignores the I/O address
// - I/O address survives reset, power-up undefined
// - Transfer count survives reset, power-up undefined
// - Sequential/idle: 16-bit count, zero clears enable
// - Repeat: low byte counts, reloads from high
// - Repeat reload restores memory address start value
// - Repeat keeps enable set; software stops it
// - Control register resets to zero, fully read/write
// - Bit 7 selects byte or word size
// - Bit 6 steps memory address up/down, 1/2
// - Idle mode holds the memory address
// - Repeat bit with end interrupt picks mode
// - Dual mode bit 4 picks source and destination
// - Single mode uses acknowledge pin as strobe
// - Channel A activation codes decode to sources
// - Channel B codes 2,3 use request pin
// - Full-address select clear runs channel independently
package dsa_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h00;
  localparam logic [7:0] OFS_IO_ADDR = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_BAND = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_WORD_BIT = 7;
  localparam int CTRL_STEP_DOWN_BIT = 6;
  localparam int CTRL_REPEAT_BIT = 5;
  localparam int CTRL_DIR_BIT = 4;
  localparam int BAND_ENABLE_BIT = 0;
  localparam int BAND_END_IRQ_BIT = 1;
  localparam int BAND_SINGLE_BIT = 2;
  localparam logic [7:0] IO_UPPER = 8'hff;
  localparam logic [23:0] STEP_BYTE = 24'h000001;
  localparam logic [23:0] STEP_WORD = 24'h000002;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_SRC = 11;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } dsa_mem_req_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_SINGLE
  } dsa_state_e;
endpackage : dsa_pkg

// File: logic/dsa_channel.sv
`timescale 1ns/1ps
module dsa_channel #(
  parameter bit IS_CHANNEL_B = 1'b0
) (
  input wire logic clk_in, // 100 MHz system clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire logic ce_in, // Clock enable, freezes all state
  input wire logic [dsa_pkg::ADDR_W-1:0] s_axi_awaddr_in, // Write addr
  input wire logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input wire logic [31:0] s_axi_wdata_in, // Write data
  input wire logic [3:0] s_axi_wstrb_in, // Write byte strobes
  input wire logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input wire logic s_axi_bready_in, // Write response ready
  input wire logic [dsa_pkg::ADDR_W-1:0] s_axi_araddr_in, // Read addr
  input wire logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read data valid
  input wire logic s_axi_rready_in, // Read data ready
  input wire logic full_address_select_in, // Pair in full-address mode
  input wire logic [dsa_pkg::NUM_SRC-1:0] periph_req_in, // Events
  input wire logic external_request_pin_n_in, // Request pin, low
  output dsa_pkg::dsa_mem_req_s mem_req_out, // System bus request
  input wire logic mem_ack_in, // System bus access done
  input wire logic [15:0] mem_rdata_in, // System bus read data
  output logic transfer_acknowledge_pin_out, // Strobe, high active
  output logic transfer_end_out // One-cycle pulse at count end
);
  import dsa_pkg::*;

  dsa_state_e state_reg;
  dsa_mem_req_s mem_req_reg;
  logic ack_pin_reg;
  logic end_reg;
  logic [23:0] mar_reg;
  logic [23:0] mar_start_reg;
  logic [15:0] io_addr_reg;
  logic [15:0] count_reg;
  logic [7:0] ctrl_reg;
  logic [2:0] band_reg;
  logic first_xfer_reg;
  logic req_sync1_reg;
  logic req_sync2_reg;
  logic req_prev_reg;

  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic ar_fire;
  logic wr_mapped;
  logic rd_mapped;
  logic [31:0] rd_value;
  logic [31:0] wr_merged;
  logic sw_mar;
  logic sw_io;
  logic sw_count;
  logic sw_ctrl;
  logic sw_band;
  logic enable;
  logic single_mode;
  logic repeat_mode;
  logic idle_mode;
  logic pin_low;
  logic pin_fall;
  logic act_hit;
  logic start;
  logic xfer_done;
  logic [23:0] io_full;
  logic [23:0] step;
  logic [15:0] count_dec;
  logic [7:0] low_dec;

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign mem_req_out = mem_req_reg;
  assign transfer_acknowledge_pin_out = ack_pin_reg;
  assign transfer_end_out = end_reg;

  // Register bus slave
  assign aw_fire = s_axi_awvalid_in & awready_reg;
  assign w_fire = s_axi_wvalid_in & wready_reg;
  assign wr_do = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign ar_fire = s_axi_arvalid_in & arready_reg;

  always_comb
  begin
    wr_mapped = 1'b1;
    case (awaddr_reg)
      OFS_MEM_ADDR, OFS_IO_ADDR, OFS_COUNT, OFS_CTRL, OFS_BAND: ;
      default: wr_mapped = 1'b0;
    endcase
  end

  assign sw_mar = ce_in & wr_do & (awaddr_reg == OFS_MEM_ADDR);
  assign sw_io = ce_in & wr_do & (awaddr_reg == OFS_IO_ADDR);
  assign sw_count = ce_in & wr_do & (awaddr_reg == OFS_COUNT);
  assign sw_ctrl = ce_in & wr_do & (awaddr_reg == OFS_CTRL);
  assign sw_band = ce_in & wr_do & (awaddr_reg == OFS_BAND);

  always_comb
  begin
    rd_mapped = 1'b1;
    rd_value = 32'h00000000;
    case (s_axi_araddr_in)
      OFS_MEM_ADDR: rd_value = {8'h00, mar_reg};
      OFS_IO_ADDR: rd_value = {16'h0000, io_addr_reg};
      OFS_COUNT: rd_value = {16'h0000, count_reg};
      OFS_CTRL: rd_value = {24'h000000, ctrl_reg};
      OFS_BAND: rd_value = {29'h00000000, band_reg};
      OFS_STATUS: rd_value = {28'h0000000, pin_low, first_xfer_reg,
                              mem_req_reg.valid, state_reg != ST_IDLE};
      default: rd_mapped = 1'b0;
    endcase
  end

  // Byte strobes merge over the current read-back image
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_lane
      logic [31:0] old_v;
      always_comb
      begin
        case (awaddr_reg)
          OFS_MEM_ADDR: old_v = {8'h00, mar_reg};
          OFS_IO_ADDR: old_v = {16'h0000, io_addr_reg};
          OFS_COUNT: old_v = {16'h0000, count_reg};
          OFS_CTRL: old_v = {24'h000000, ctrl_reg};
          default: old_v = {29'h00000000, band_reg};
        endcase
      end
      assign wr_merged[gi*8 +: 8] = wstrb_reg[gi] ?
        wdata_reg[gi*8 +: 8] : old_v[gi*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (ce_in)
    begin
      awready_reg <= ~aw_fire & ~aw_hold_reg & ~bvalid_reg & ~wr_do;
      wready_reg <= ~w_fire & ~w_hold_reg & ~bvalid_reg & ~wr_do;
      if (aw_fire)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (w_fire)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
      if (wr_do)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg & s_axi_bready_in)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end
    else if (ce_in)
    begin
      arready_reg <= ~ar_fire & ~rvalid_reg;
      if (ar_fire)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_value;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready_in)
        rvalid_reg <= 1'b0;
    end
  end

  // Mode decode
  assign enable = band_reg[BAND_ENABLE_BIT];
  assign single_mode = band_reg[BAND_SINGLE_BIT];
  assign repeat_mode = ctrl_reg[CTRL_REPEAT_BIT] &
                       ~band_reg[BAND_END_IRQ_BIT];
  assign idle_mode = ctrl_reg[CTRL_REPEAT_BIT] &
                     band_reg[BAND_END_IRQ_BIT];
  assign io_full = {IO_UPPER, io_addr_reg};
  assign step = ctrl_reg[CTRL_WORD_BIT] ? STEP_WORD : STEP_BYTE;
  assign count_dec = count_reg - 16'h0001;
  assign low_dec = count_reg[7:0] - 8'h01;

  // Request pin comes from outside: two stages before any use
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      req_sync1_reg <= 1'b1;
      req_sync2_reg <= 1'b1;
      req_prev_reg <= 1'b1;
    end
    else if (ce_in)
    begin
      req_sync1_reg <= external_request_pin_n_in;
      req_sync2_reg <= req_sync1_reg;
      req_prev_reg <= req_sync2_reg;
    end
  end

  assign pin_low = ~req_sync2_reg;
  assign pin_fall = req_prev_reg & ~req_sync2_reg;

  always_comb
  begin
    act_hit = 1'b0;
    case (ctrl_reg[3:0])
      4'h1: act_hit = periph_req_in[0];
      4'h2: act_hit = IS_CHANNEL_B &
              (first_xfer_reg ? pin_low : pin_fall);
      4'h3: act_hit = IS_CHANNEL_B & pin_low;
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd:
        act_hit = periph_req_in[4'(ctrl_reg[3:0] - 4'h3)];
      default: act_hit = 1'b0;
    endcase
  end

  // Full-address pairing belongs to other logic; stay out of its way
  assign start = ce_in & (state_reg == ST_IDLE) & enable & act_hit &
                 ~full_address_select_in;
  assign xfer_done = ce_in & mem_ack_in &
                     ((state_reg == ST_WRITE) | (state_reg == ST_SINGLE));

  // Transfer sequencer
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= ST_IDLE;
      mem_req_reg <= '0;
      ack_pin_reg <= 1'b0;
      end_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      end_reg <= xfer_done & ~repeat_mode & (count_dec == 16'h0000);
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            mem_req_reg.valid <= 1'b1;
            mem_req_reg.word <= ctrl_reg[CTRL_WORD_BIT];
            if (single_mode)
            begin
              // Far device follows the strobe for its half
              state_reg <= ST_SINGLE;
              mem_req_reg.write <= ctrl_reg[CTRL_DIR_BIT];
              mem_req_reg.addr <= mar_reg;
              ack_pin_reg <= 1'b1;
            end
            else
            begin
              state_reg <= ST_READ;
              mem_req_reg.write <= 1'b0;
              mem_req_reg.addr <= ctrl_reg[CTRL_DIR_BIT] ?
                                  io_full : mar_reg;
            end
          end
        end
        ST_READ:
        begin
          if (mem_ack_in)
          begin
            state_reg <= ST_WRITE;
            mem_req_reg.write <= 1'b1;
            mem_req_reg.wdata <= mem_rdata_in;
            mem_req_reg.addr <= ctrl_reg[CTRL_DIR_BIT] ?
                                mar_reg : io_full;
          end
        end
        ST_WRITE, ST_SINGLE:
        begin
          if (mem_ack_in)
          begin
            state_reg <= ST_IDLE;
            mem_req_reg.valid <= 1'b0;
            ack_pin_reg <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Memory-side address and its restart copy
  always_ff @(posedge clk_in)
  begin
    if (ce_in)
    begin
      if (sw_mar)
      begin
        mar_reg <= wr_merged[23:0];
        mar_start_reg <= wr_merged[23:0];
      end
      else if (xfer_done)
      begin
        if (repeat_mode & (low_dec == 8'h00))
          mar_reg <= mar_start_reg;
        else if (idle_mode)
          mar_reg <= mar_reg;
        else if (ctrl_reg[CTRL_STEP_DOWN_BIT])
          mar_reg <= mar_reg - step;
        else
          mar_reg <= mar_reg + step;
      end
    end
  end

  // No reset: software owns these values across reset
  always_ff @(posedge clk_in)
  begin
    if (sw_io)
      io_addr_reg <= wr_merged[15:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (sw_count)
      count_reg <= wr_merged[15:0];
    else if (xfer_done)
    begin
      if (repeat_mode)
        count_reg[7:0] <= (low_dec == 8'h00) ?
                          count_reg[15:8] : low_dec;
      else
        count_reg <= count_dec;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctrl_reg <= CTRL_RESET;
    else if (sw_ctrl)
      ctrl_reg <= wr_merged[7:0];
  end

  // A software write in the same cycle wins over the hardware stop
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      band_reg <= 3'h0;
      first_xfer_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sw_band)
      begin
        band_reg <= wr_merged[2:0];
        if (wr_merged[BAND_ENABLE_BIT] & ~enable)
          first_xfer_reg <= 1'b1;
      end
      else if (xfer_done & ~repeat_mode & (count_dec == 16'h0000))
        band_reg[BAND_ENABLE_BIT] <= 1'b0;
      if (xfer_done & ~sw_band)
        first_xfer_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_rep_wrap;
    xfer_done && repeat_mode && !sw_count && !sw_mar &&
      count_reg[7:0] == 8'h01;
  endsequence

  sequence s_seq_last;
    xfer_done && !repeat_mode && !sw_band && count_reg == 16'h0001;
  endsequence

  io_upper_a: assert property (
    state_reg == ST_READ && ctrl_reg[CTRL_DIR_BIT] |->
      mem_req_reg.addr[23:16] == IO_UPPER)
    else $error("I/O side address upper byte not all ones");
  // Unwritten after power-up: case equality keeps that quiet
  io_fixed_a: assert property (
    !sw_io |=> io_addr_reg === $past(io_addr_reg))
    else $error("I/O side address changed without a write");
  single_mar_a: assert property (
    start && single_mode |=> mem_req_reg.addr == $past(mar_reg))
    else $error("Single address transfer did not use memory address");
  seq_stop_a: assert property (
    s_seq_last |=> !enable && end_reg)
    else $error("Channel still enabled at count end");
  rep_reload_a: assert property (
    s_rep_wrap |=> count_reg[7:0] == count_reg[15:8] &&
      mar_reg == mar_start_reg)
    else $error("Repeat count or address not reloaded");
  rep_keep_a: assert property (
    (s_rep_wrap and !sw_band) |=>
      enable ##1 (enable || $past(sw_band)))
    else $error("Repeat mode dropped the enable");
  // Must look at reset itself, so the default disable is overridden
  ctrl_reset_a: assert property (
    disable iff (1'b0) rst_in |=> ctrl_reg == CTRL_RESET)
    else $error("Control register not cleared by reset");
  word_step_a: assert property (
    xfer_done && !sw_mar && !idle_mode && !repeat_mode &&
      ctrl_reg[CTRL_WORD_BIT] && !ctrl_reg[CTRL_STEP_DOWN_BIT] |=>
      mar_reg == $past(mar_reg) + STEP_WORD)
    else $error("Word transfer did not step address by two");
  idle_hold_a: assert property (
    xfer_done && idle_mode && !sw_mar |=> $stable(mar_reg))
    else $error("Idle mode moved the memory address");
  no_start_a: assert property (
    state_reg == ST_IDLE && (ctrl_reg[3:0] == 4'h0 ||
      ctrl_reg[3:0] == 4'he || ctrl_reg[3:0] == 4'hf) |=>
      state_reg == ST_IDLE)
    else $error("Transfer started from an unused activation code");
  strobe_a: assert property (
    start && single_mode |=> ack_pin_reg && mem_req_reg.valid)
    else $error("Acknowledge strobe missing on single transfer");
endmodule : dsa_channel

// File: testbench/dsa_mem_model.sv
`timescale 1ns/1ps
module dsa_mem_model
  import dsa_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire dsa_pkg::dsa_mem_req_s mem_req_in, // Channel request
  input wire logic strobe_in, // Acknowledge pin of the channel
  input wire logic [7:0] lat_in, // Wait cycles before each answer
  output logic mem_ack_out, // One-cycle access done
  output logic [15:0] mem_rdata_out // Read data
);
  dsa_mem_req_s seen[$];
  logic strb[$];
  int wait_cnt = 0;
  initial
  begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 16'h0;
  end
  always @(posedge clk_in)
  begin
    if (mem_req_in.valid && !mem_ack_out && wait_cnt >= lat_in)
    begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= {~mem_req_in.addr[7:0], mem_req_in.addr[15:8]};
      wait_cnt <= 0;
    end
    else
    begin
      mem_ack_out <= 1'b0;
      // Released bus toggles so a stale value never looks valid
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in.valid && !mem_ack_out)
        wait_cnt <= wait_cnt + 1;
    end
  end
  // Logged mid-cycle so the bench never races the acknowledge edge
  always @(negedge clk_in)
  begin
    if (mem_ack_out)
    begin
      seen.push_back(mem_req_in);
      strb.push_back(strobe_in);
    end
  end
endmodule : dsa_mem_model

// File: testbench/dsa_channel_tb_top.sv
`timescale 1ns/1ps
module dsa_channel_tb_top;
  import dsa_pkg::*;
  logic clk_in = 0, rst_in = 1, fas = 0, awv = 0, wv = 0, bry = 0;
  logic arv = 0, rry = 0, awr, wr_r, bv, arr, rv, ack, strobe, tend;
  logic [7:0] awa = 0, ara = 0, lat = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] br, rr;
  logic [10:0] preq = 0;
  logic [15:0] mrd;
  dsa_mem_req_s mreq;
  int err_total = 0, total_checks = 0, issued = 0, ends = 0;
  logic busy_q = 0, pin_n = 1;
  always #5 clk_in = ~clk_in;
  dsa_channel #(.IS_CHANNEL_B(1'b1)) dsa_channel_inst (.clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(1'b1), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .full_address_select_in(fas), .periph_req_in(preq),
    .external_request_pin_n_in(pin_n), .mem_req_out(mreq), .mem_ack_in(ack),
    .mem_rdata_in(mrd), .transfer_acknowledge_pin_out(strobe),
    .transfer_end_out(tend));
  dsa_mem_model dsa_mem_model_inst (.clk_in(clk_in), .mem_req_in(mreq),
    .strobe_in(strobe), .lat_in(lat), .mem_ack_out(ack),
    .mem_rdata_out(mrd));
  always @(negedge clk_in)
  begin
    if (mreq.valid && !busy_q)
      issued++;
    busy_q = mreq.valid && !ack;
    if (tend)
      ends++;
  end
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic guard(input int i);
    if (i >= 300)
    begin
      err_total++;
      $display("Error wait expected answer seen timeout");
      tally_and_finish();
    end
  endtask : guard
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e);
    int i;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) break;
    end
    guard(i);
    chk("bresp", br, e);
    bry <= 1'b0;
    @(posedge clk_in);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] e);
    int i;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (i = 0; i < 300; i++)
    begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    guard(i);
    d = rd;
    e = rr;
    rry <= 1'b0;
    @(posedge clk_in);
  endtask : axi_rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0] e;
    axi_rd(a, d, e);
    chk($sformatf("reg %h", a), d, x);
  endtask : rchk
  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
  endtask : do_reset
  task automatic xfer(input logic [7:0] c, input logic [2:0] band,
    input logic [15:0] cnt, input int n, input logic [7:0] l);
    logic [23:0] mar0, m, src, dst;
    logic [15:0] io, mask;
    logic [10:0] req;
    logic rpt, idle, sgl;
    int i, k, pos, step, need;
    mar0 = {8'h00, 2'b01, 14'($urandom)};
    io = 16'($urandom);
    rpt = c[5] && !band[1];
    idle = c[5] && band[1];
    sgl = band[2];
    step = c[7] ? 2 : 1;
    need = sgl ? n : 2 * n;
    mask = c[7] ? 16'hffff : 16'h00ff;
    req = '0;
    if (c[3:0] == 4'h1)
      req[0] = 1'b1;
    else if (c[3:0] >= 4'h4 && c[3:0] <= 4'hd)
      req[c[3:0] - 4'h3] = 1'b1;
    if (n == 0)
      req = '1;
    dsa_mem_model_inst.seen.delete();
    dsa_mem_model_inst.strb.delete();
    issued = 0;
    ends = 0;
    lat <= l;
    axi_wr(OFS_MEM_ADDR, {8'h0, mar0}, RESP_OKAY);
    axi_wr(OFS_IO_ADDR, {16'h0, io}, RESP_OKAY);
    axi_wr(OFS_COUNT, {16'h0, cnt}, RESP_OKAY);
    axi_wr(OFS_CTRL, {24'h0, c}, RESP_OKAY);
    axi_wr(OFS_BAND, {29'h0, band}, RESP_OKAY);
    preq <= req;
    pin_n <= !(n > 0 && c[3:1] == 3'b001);
    for (i = 0; i < 300 && (n == 0 ? i < 40 : issued < need); i++)
      @(posedge clk_in);
    guard(i);
    preq <= '0;
    pin_n <= 1'b1;
    repeat (20) @(posedge clk_in);
    if (!rpt)
      chk("accesses", dsa_mem_model_inst.seen.size(), need);
    for (k = 0; k <= n; k++)
    begin
      pos = (rpt && k >= cnt[7:0]) ? (k - cnt[7:0]) % cnt[15:8] : k;
      m = idle ? mar0 : c[6] ? mar0 - 24'(pos * step) :
        mar0 + 24'(pos * step);
      if (k == n)
        break;
      src = c[4] ? {8'hff, io} : m;
      dst = c[4] ? m : {8'hff, io};
      if (sgl)
      begin
        chk("saddr", dsa_mem_model_inst.seen[k].addr, m);
        chk("swr", dsa_mem_model_inst.seen[k].write, c[4]);
        chk("strobe", dsa_mem_model_inst.strb[k], 1'b1);
      end
      else
      begin
        chk("src", dsa_mem_model_inst.seen[2*k].addr, src);
        chk("nostrobe", dsa_mem_model_inst.strb[2*k], 1'b0);
        chk("dst", dsa_mem_model_inst.seen[2*k+1].addr, dst);
        chk("dir", {dsa_mem_model_inst.seen[2*k].write,
          dsa_mem_model_inst.seen[2*k+1].write}, 2'b01);
        chk("data", dsa_mem_model_inst.seen[2*k+1].wdata & mask,
          {~src[7:0], src[15:8]} & mask);
      end
      chk("size", dsa_mem_model_inst.seen[k].word, c[7]);
    end
    rchk(OFS_IO_ADDR, {16'h0, io});
    if (n > 0)
    begin
      chk("ends", ends, rpt ? 0 : 1);
      rchk(OFS_BAND, {29'h0, band[2:1], rpt});
      rchk(OFS_MEM_ADDR, {8'h0, m});
      rchk(OFS_COUNT, {16'h0, rpt ? {2{cnt[15:8]}} : 16'h0});
    end
    axi_wr(OFS_BAND, 32'h0, RESP_OKAY);
    $display("Test transfer ctrl %h done", c);
  endtask : xfer
  initial
  begin : main
    logic [31:0] d;
    logic [1:0] e;
    logic [7:0] r;
    int c;
    void'($urandom(66585));
    do_reset();
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_BAND, 32'h0);
    axi_rd(8'h18, d, e);
    chk("unmapped", e, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'h1, RESP_SLVERR);
    r = 8'($urandom);
    axi_wr(OFS_CTRL, {24'h0, r}, RESP_OKAY);
    rchk(OFS_CTRL, {24'h0, r});
    axi_wr(OFS_IO_ADDR, 32'h1234a5c3, RESP_OKAY);
    axi_wr(OFS_COUNT, 32'h00003c5a, RESP_OKAY);
    do_reset();
    rchk(OFS_IO_ADDR, 32'h0000a5c3);
    rchk(OFS_COUNT, 32'h00003c5a);
    rchk(OFS_CTRL, 32'h0);
    $display("Test registers done");
    xfer(8'h01, 3'b001, 16'h0003, 3, 0);
    xfer(8'hd4, 3'b011, 16'h0002, 2, 3);
    xfer(8'h28, 3'b011, 16'h0003, 3, 1);
    xfer(8'h2d, 3'b001, 16'h0202, 4, 1);
    xfer(8'h05, 3'b101, 16'h0002, 2, 0);
    xfer(8'h96, 3'b101, 16'h0001, 1, 2);
    xfer(8'h83, 3'b101, 16'h0001, 1, 1);
    xfer(8'h12, 3'b001, 16'h0001, 1, 0);
    for (c = 0; c < 16; c++)
      xfer({2'($urandom), 1'b0, 1'($urandom), 4'(c)}, 3'b001, 16'h0001,
        (c == 1 || (c >= 4 && c <= 13)) ? 1 : 0, 8'(c % 3));
    fas <= 1'b1;
    xfer(8'h01, 3'b001, 16'h0001, 0, 0);
    fas <= 1'b0;
    tally_and_finish();
  end
endmodule : dsa_channel_tb_top
